// ===== pht_pkg.sv
//======================================================================
// pcm highway timeslot port: shared constants and types
//======================================================================
package pht_pkg;

    // register offsets on the internal register port
    localparam logic [7:0] ADDR_TX_LO = 8'h36;
    localparam logic [7:0] ADDR_TX_HI = 8'h37;
    localparam logic [7:0] ADDR_RX_LO = 8'h38;
    localparam logic [7:0] ADDR_RX_HI = 8'h39;
    localparam logic [7:0] START_RST  = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // frame geometry and bit clock range
    localparam int SLOTS_MIN    = 4;
    localparam int SLOTS_MAX    = 128;
    localparam int SLOT_BITS    = 8;
    localparam int MCLK_KHZ     = 50000;
    localparam int PCLK_MIN_KHZ = 256;
    localparam int PCLK_MAX_KHZ = 8192;
    // mclk samples per half bit clock at the fastest rate (rounded down)
    localparam int PCLK_HALF_CYC = MCLK_KHZ / (2 * PCLK_MAX_KHZ);

    // counters and sample widths
    localparam int CNT_W    = 16;
    localparam int SAMPLE_W = 16;
    localparam int FIFO_DEPTH = 32;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [3:0]  LAST8    = 4'h7;
    localparam logic [3:0]  LAST16   = 4'hF;
    localparam logic [3:0]  IDX_ZERO = 4'h0;
    localparam logic [7:0]  PAD8     = 8'h00;

    // sample formats; companding itself is outside this block
    typedef enum logic [1:0] {PHT_FMT_MULAW, PHT_FMT_ALAW, PHT_FMT_LIN8, PHT_FMT_LIN16} pht_fmt_e;

    // mode settings
    typedef struct packed {
        logic     enable;
        logic     tristateEdgeSelect;
        pht_fmt_e sampleFormatSelect;
    } pht_mode_s;

    // slot start counts of both directions
    typedef struct packed {
        logic [15:0] txStart;
        logic [15:0] rxStart;
    } pht_slot_cfg_s;

endpackage

// ===== pht_highway_port.sv
`timescale 1ns/1ps
//======================================================================
// receive sample fifo
//======================================================================
module pht_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
)
(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // filling side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // draining side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // honest flags from the occupancy count
    assign inReady  = (count != FULL_CNT);
    assign outValid = (count != '0);
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;
    assign outData  = mem[rdPtr];

    // storage; depth must be a power of two so pointers wrap
    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wrPtr] <= inData;
    end

    // pointers and count
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wrPtr <= wrPtr + 1'b1;
            if (pop)
                rdPtr <= rdPtr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end

    a_fifo_no_overfill: assert property (@(posedge mclk) disable iff (srst)
        count <= FULL_CNT) else $error("fifo count above depth");

endmodule

//======================================================================
// pcm highway timeslot port
//======================================================================
module pht_highway_port
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 srst,
    // highway pins
    input  wire logic                 pclkPin,
    input  wire logic                 frameSync,
    input  wire logic                 serialRxIn,
    output logic                      serialTxOut,
    output logic                      serialTxOe,
    // register port from the control interface
    input  wire logic [7:0]           regAddr,
    input  wire logic                 regWrEn,
    input  wire logic [7:0]           regWrData,
    output logic [7:0]                regRdData,
    // mode settings
    input  wire pht_pkg::pht_mode_s   mode,
    // transmit samples in
    input  wire logic [15:0]          txSample,
    input  wire logic                 txValid,
    output logic                      txReady,
    // receive samples out
    output logic [15:0]               rxSample,
    output logic                      rxValid,
    input  wire logic                 rxReady,
    // status
    input  wire logic                 overrunClear,
    output logic                      rxOverrun,
    output logic                      frameSeen
);
    import pht_pkg::*;

    logic [2:0]    syncA;
    logic [2:0]    syncB;
    logic [2:0]    pinPrev;
    logic          pclkRise;
    logic          pclkFall;
    logic          fsyncLast;
    logic          frameStart;
    logic [15:0]   bitCount;
    logic [15:0]   next_bitCount;
    pht_slot_cfg_s cfg;
    logic [7:0]    txLo;
    logic [7:0]    txHi;
    logic [7:0]    rxLo;
    logic [7:0]    rxHi;
    logic          lin16;
    logic [3:0]    lastIdx;
    logic          txHit;
    logic          rxHit;
    logic [15:0]   txHold;
    logic          txHoldValid;
    logic [15:0]   txShift;
    logic          txActive;
    logic [3:0]    txIdx;
    logic [15:0]   rxShift;
    logic          rxActive;
    logic [3:0]    rxIdx;
    logic          rxDone;
    logic [15:0]   rxHold;
    logic          rxHoldValid;
    logic          fifoInReady;

    //==================================================================
    // pin synchronisers and bit clock edges
    //==================================================================
    // the first stage feeds only the second; edges come from later stages
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            syncA   <= '0;
            syncB   <= '0;
            pinPrev <= '0;
        end
        else
        begin
            syncA   <= {serialRxIn, frameSync, pclkPin};
            syncB   <= syncA;
            pinPrev <= syncB;
        end
    end

    // rate limit: 50 MHz gives at least three samples per half period
    assign pclkRise = syncB[0] & ~pinPrev[0];
    assign pclkFall = ~syncB[0] & pinPrev[0];

    //==================================================================
    // frame timing
    //==================================================================
    // frame restart: sync seen high at a rising edge after low
    assign frameStart = pclkRise & syncB[1] & ~fsyncLast;

    // frame length: counter saturates, so up to 128 slots fit easily
    always_comb
    begin
        if (frameStart)
            next_bitCount = CNT_ZERO;
        else if (bitCount != CNT_MAX)
            next_bitCount = bitCount + 1'b1;
        else
            next_bitCount = bitCount;
    end

    // bit clock timing: count advances only on rising bit clock edges
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            bitCount  <= CNT_MAX;
            fsyncLast <= 1'b0;
            frameSeen <= 1'b0;
        end
        else if (pclkRise)
        begin
            bitCount  <= next_bitCount;
            fsyncLast <= syncB[1];
            frameSeen <= frameSeen | frameStart;
        end
    end

    //==================================================================
    // start count registers
    //==================================================================
    // tx rewrite: tx counts accept writes at any time
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            txLo <= START_RST;
            txHi <= START_RST;
            rxLo <= START_RST;
            rxHi <= START_RST;
        end
        else if (regWrEn)
        begin
            unique case (regAddr)
                ADDR_TX_LO: txLo <= regWrData;
                ADDR_TX_HI: txHi <= regWrData;
                ADDR_RX_LO: rxLo <= regWrData;
                ADDR_RX_HI: rxHi <= regWrData;
                default:    ;
            endcase
        end
    end

    // readback, registered; unmapped addresses read zero
    always_ff @(posedge mclk)
    begin
        if (srst)
            regRdData <= RD_UNMAPPED;
        else
        begin
            unique case (regAddr)
                ADDR_TX_LO: regRdData <= txLo;
                ADDR_TX_HI: regRdData <= txHi;
                ADDR_RX_LO: regRdData <= rxLo;
                ADDR_RX_HI: regRdData <= rxHi;
                default:    regRdData <= RD_UNMAPPED;
            endcase
        end
    end

    // separate starts: each direction compares its own pair
    assign cfg.txStart = {txHi, txLo};
    assign cfg.rxStart = {rxHi, rxLo};

    // test mode: linear 16-bit spans two slots
    assign lin16   = (mode.sampleFormatSelect == PHT_FMT_LIN16);
    assign lastIdx = lin16 ? LAST16 : LAST8;

    // layouts by count: sync variants and slot styles need no extra logic
    // start match: a count past the frame length never fires
    assign txHit = pclkRise & mode.enable & (frameSeen | frameStart)
                 & (next_bitCount == cfg.txStart);
    assign rxHit = pclkRise & mode.enable & (frameSeen | frameStart)
                 & (next_bitCount == cfg.rxStart);

    //==================================================================
    // transmit path
    //==================================================================
    assign txReady = ~txHoldValid;

    // one sample holding slot; an empty slot sends zero rather than stall
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            txHold      <= '0;
            txHoldValid <= 1'b0;
        end
        else if (txHit)
            txHoldValid <= 1'b0;
        else if (txValid && txReady)
        begin
            txHold      <= txSample;
            txHoldValid <= 1'b1;
        end
    end

    // msb first: load at the start count, shift once per bit clock
    // companded layout: sign bit leads, so it is sent first
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            txShift  <= '0;
            txActive <= 1'b0;
            txIdx    <= IDX_ZERO;
        end
        else if (txHit)
        begin
            txShift  <= lin16 ? (txHoldValid ? txHold : '0)
                              : {(txHoldValid ? txHold[7:0] : PAD8), PAD8};
            txActive <= 1'b1;
            txIdx    <= lastIdx;
        end
        else if (pclkRise && txActive)
        begin
            if (txIdx == IDX_ZERO)
                txActive <= 1'b0;
            else
            begin
                txShift <= {txShift[14:0], 1'b0};
                txIdx   <= txIdx - 1'b1;
            end
        end
    end

    assign serialTxOut = txShift[15];

    // drive window: enable only while our own sample is out
    // release edge: falling edge mid last bit if tristateEdgeSelect is low, else the rising edge that ends it
    always_ff @(posedge mclk)
    begin
        if (srst)
            serialTxOe <= 1'b0;
        else if (txHit)
            serialTxOe <= 1'b1;
        else if (txActive && txIdx == IDX_ZERO && (pclkRise
                 || (pclkFall && !mode.tristateEdgeSelect)))
            serialTxOe <= 1'b0;
    end

    //==================================================================
    // receive path
    //==================================================================
    // linear order: sixteen bits captured msb first back to back
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rxShift  <= '0;
            rxActive <= 1'b0;
            rxIdx    <= IDX_ZERO;
            rxDone   <= 1'b0;
        end
        else
        begin
            rxDone <= 1'b0;
            if (rxHit)
            begin
                rxActive <= 1'b1;
                rxIdx    <= lastIdx;
            end
            else if (pclkFall && rxActive)
            begin
                rxShift <= {rxShift[14:0], syncB[2]};
                if (rxIdx == IDX_ZERO)
                begin
                    rxActive <= 1'b0;
                    rxDone   <= 1'b1;
                end
                else
                    rxIdx <= rxIdx - 1'b1;
            end
        end
    end

    // hold waits for fifo room; a second sample meanwhile is dropped
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rxHold      <= '0;
            rxHoldValid <= 1'b0;
        end
        else if (rxDone && (!rxHoldValid || fifoInReady))
        begin
            rxHold      <= lin16 ? rxShift : {PAD8, rxShift[7:0]};
            rxHoldValid <= 1'b1;
        end
        else if (fifoInReady)
            rxHoldValid <= 1'b0;
    end

    // sticky overrun; a new loss beats a clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (srst)
            rxOverrun <= 1'b0;
        else if (rxDone && rxHoldValid && !fifoInReady)
            rxOverrun <= 1'b1;
        else if (overrunClear)
            rxOverrun <= 1'b0;
    end

    pht_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rxFifo (
        .mclk     (mclk),
        .srst     (srst),
        .inValid  (rxHoldValid),
        .inReady  (fifoInReady),
        .inData   (rxHold),
        .outValid (rxValid),
        .outReady (rxReady),
        .outData  (rxSample)
    );

    //==================================================================
    // checks
    //==================================================================
    a_frame_restart: assert property (@(posedge mclk) disable iff (srst)
        frameStart |=> bitCount == CNT_ZERO) else $error("count not zero after sync");

    a_tx_start_match: assert property (@(posedge mclk) disable iff (srst)
        $rose(serialTxOe) |-> bitCount == cfg.txStart && mode.enable)
        else $error("tx began off its start count");

    a_tx_hiz_idle: assert property (@(posedge mclk) disable iff (srst)
        !txActive |-> !serialTxOe) else $error("tx driven outside its sample");

    a_release_fall: assert property (@(posedge mclk) disable iff (srst)
        txActive && txIdx == IDX_ZERO && pclkFall && !mode.tristateEdgeSelect && !txHit
        |=> !serialTxOe) else $error("no release on falling edge");

    a_release_rise: assert property (@(posedge mclk) disable iff (srst)
        txActive && txIdx == IDX_ZERO && pclkRise && !txHit
        |=> !serialTxOe && !txActive) else $error("no release after last bit");

    a_width_select: assert property (@(posedge mclk) disable iff (srst)
        txHit |=> txIdx == ((mode.sampleFormatSelect == PHT_FMT_LIN16) ? LAST16 : LAST8))
        else $error("wrong sample width");

    a_msb_first: assert property (@(posedge mclk) disable iff (srst)
        txHit && txHoldValid && lin16 |=> serialTxOut == $past(txHold[15]))
        else $error("msb not sent first");

    a_tx_rewrite: assert property (@(posedge mclk) disable iff (srst)
        regWrEn && regAddr == ADDR_TX_LO |=> txLo == $past(regWrData))
        else $error("tx start write lost");

    a_rx_capture: assert property (@(posedge mclk) disable iff (srst)
        rxHit ##1 (!rxHit && !pclkFall) [*2] |-> rxActive && rxIdx == lastIdx)
        else $error("rx window not opened");

endmodule

// ===== pht_pcm_master.sv
`timescale 1ns/1ps
//======================================================================
// pcm bus master: bit clock, frame sync, receive data, transmit capture
//======================================================================
module pht_pcm_master
#(
    parameter int HALF_NS = 244,
    parameter int BITS    = 32,
    parameter int TAIL_NS = 150
)
(
    // highway pins
    output logic             pclkPin,
    output logic             frameSync,
    output logic             serialRxIn,
    input  wire logic        serialTxOut,
    input  wire logic        serialTxOe,
    // slot placement known to the master
    input  wire logic [15:0] txAt,
    input  wire logic [4:0]  txBits,
    input  wire logic        capEn,
    input  wire logic [15:0] rxAt,
    input  wire logic [4:0]  rxBits,
    input  wire logic [15:0] rxWord,
    // capture results
    output logic [15:0]      capWord,
    output logic             capTail,
    output logic [15:0]      capCount,
    output logic [15:0]      strayCount,
    output logic             frameTick
);
    logic        dtxWire;
    logic [15:0] shiftIn;
    int          fb;

    // pulldown on the data line: a released driver reads low
    assign dtxWire = serialTxOe ? serialTxOut : 1'b0;

    initial
    begin
        pclkPin = 1'b0;
        frameSync = 1'b0;
        serialRxIn = 1'b0;
        frameTick = 1'b0;
        fb = 0;
        forever
        begin
            for (int b = 0; b < BITS; b++)
            begin
                #(HALF_NS);
                pclkPin = 1'b1;
                fb = b;
                // outside the slot the line toggles so a stale bit never looks valid
                if (b >= rxAt && b < rxAt + rxBits)
                    serialRxIn = rxWord[rxBits - 1 - (b - rxAt)];
                else
                    serialRxIn = ~serialRxIn;
                #(HALF_NS);
                pclkPin = 1'b0;
                if (b == 0)
                    frameTick = ~frameTick;
                // short sync: high across the rising edge of bit 0
                frameSync = (b == BITS - 1);
            end
        end
    end

    initial
    begin
        capCount = 16'h0000;
        strayCount = 16'h0000;
        capWord = 16'h0000;
        capTail = 1'b0;
        shiftIn = 16'h0000;
        forever
        begin
            @(negedge pclkPin);
            if (fb >= txAt && fb < txAt + txBits)
            begin
                shiftIn = {shiftIn[14:0], dtxWire};
                if (capEn && fb == txAt + txBits - 1)
                begin
                    // late look at the enable tells the two release edges apart
                    #(TAIL_NS);
                    capTail = serialTxOe;
                    capWord = (txBits == 5'h10) ? shiftIn : {8'h00, shiftIn[7:0]};
                    capCount = capCount + 16'h0001;
                end
            end
            else if (serialTxOe === 1'b1)
                strayCount = strayCount + 16'h0001;
        end
    end
endmodule

// ===== pht_highway_port_test.sv
`timescale 1ns/1ps
//======================================================================
// self-checking bench for the pcm highway timeslot port
//======================================================================
module pht_highway_port_test;
    import pht_pkg::*;

    logic        mclk;
    logic        srst;
    logic        pclkPin;
    logic        frameSync;
    logic        serialRxIn;
    logic        serialTxOut;
    logic        serialTxOe;
    logic [7:0]  regAddr;
    logic        regWrEn;
    logic [7:0]  regWrData;
    logic [7:0]  regRdData;
    pht_mode_s   mode;
    logic [15:0] txSample;
    logic        txValid;
    logic        txReady;
    logic [15:0] rxSample;
    logic        rxValid;
    logic        rxReady;
    logic        overrunClear;
    logic        rxOverrun;
    logic        frameSeen;
    logic [15:0] txAt;
    logic [15:0] rxAt;
    logic [15:0] rxWord;
    logic [15:0] capWord;
    logic [15:0] capCount;
    logic [15:0] strayCount;
    logic [4:0]  txBits;
    logic [4:0]  rxBits;
    logic        capEn;
    logic        capTail;
    logic        frameTick;
    logic [7:0]  d;
    logic [16:0] txExp;
    logic [15:0] rxExp;
    logic [16:0] txQ[$];
    logic [15:0] rxQ[$];
    int          fail_count;
    int          check_count;

    pht_highway_port dut
    (
        .mclk, .srst, .pclkPin, .frameSync, .serialRxIn, .serialTxOut, .serialTxOe,
        .regAddr, .regWrEn, .regWrData, .regRdData, .mode, .txSample, .txValid,
        .txReady, .rxSample, .rxValid, .rxReady, .overrunClear, .rxOverrun, .frameSeen
    );
    pht_pcm_master farEnd
    (
        .pclkPin, .frameSync, .serialRxIn, .serialTxOut, .serialTxOe, .txAt, .txBits,
        .capEn, .rxAt, .rxBits, .rxWord, .capWord, .capTail, .capCount, .strayCount,
        .frameTick
    );

    // 50 MHz system clock
    initial
    begin
        mclk = 1'b0;
        forever
            #10 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge mclk);
        regWrEn = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        regAddr = a;
        @(negedge mclk);
        check("regRdData", {9'h000, exp}, {9'h000, regRdData});
    endtask

    task automatic wait_frames(input int n);
        repeat (n) @(frameTick);
        @(negedge mclk);
    endtask

    // one slot: program at a frame start, let two frames settle, capture the third
    task automatic tx_case(input pht_fmt_e f, input logic [15:0] st, input logic tr,
                           input logic [15:0] s, input logic v);
        logic [4:0] nb;
        nb = (f == PHT_FMT_LIN16) ? 5'h10 : 5'h08;
        wait_frames(1);
        capEn = 1'b0;
        mode = pht_mode_s'({1'b1, tr, f});
        reg_write(ADDR_TX_HI, st[15:8]);
        reg_write(ADDR_TX_LO, st[7:0]);
        txSample = s;
        txValid = v;
        txAt = st;
        txBits = nb;
        wait_frames(2);
        txQ.push_back({tr, (nb == 5'h10) ? (s & {16{v}}) : {8'h00, s[7:0] & {8{v}}}});
        capEn = 1'b1;
    endtask

    // watcher: each capture takes the oldest note; a surplus capture always mismatches
    always @(capCount)
        if (capCount !== 16'h0000)
        begin
            check("tx surplus", 17'h0, 17'(txQ.size() == 0));
            txExp = (txQ.size() > 0) ? txQ.pop_front() : 17'h00000;
            check("tx word", txExp, {capTail, capWord});
        end

    // watcher: each fifo pop takes the oldest receive note
    always @(posedge mclk)
        if (rxValid === 1'b1 && rxReady === 1'b1)
        begin
            check("rx surplus", 17'h0, 17'(rxQ.size() == 0));
            rxExp = (rxQ.size() > 0) ? rxQ.pop_front() : 16'h0000;
            check("rxSample", {1'b0, rxExp}, {1'b0, rxSample});
        end

    // watchdog well past the expected run of about one millisecond
    initial
    begin
        #1800000;
        fail_count++;
        $display("wrong value run time expected done seen timeout");
        give_verdict();
    end

    initial
    begin
        srst = 1'b1;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        mode = pht_mode_s'(4'h0);
        txSample = 16'h0000;
        txValid = 1'b0;
        rxReady = 1'b0;
        overrunClear = 1'b0;
        txAt = 16'h0028;
        rxAt = 16'h0028;
        rxWord = 16'h0000;
        txBits = 5'h08;
        rxBits = 5'h08;
        capEn = 1'b0;
        fail_count = 0;
        check_count = 0;
        void'($urandom(32'hEDB8));
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        @(negedge mclk);
        check("serialTxOe", 17'h0, 17'(serialTxOe));
        check("txReady", 17'h1, 17'(txReady));
        check("frameSeen", 17'h0, 17'(frameSeen));
        // start registers: reset value, write and read back, one unmapped place
        for (int a = 8'h36; a <= 8'h3A; a++)
            reg_read(8'(a), 8'h00);
        for (int a = 8'h36; a <= 8'h3A; a++)
        begin
            d = 8'($urandom);
            reg_write(8'(a), d);
            reg_read(8'(a), (a == 8'h3A) ? 8'h00 : d);
        end
        // both starts parked beyond the 32-bit frame, then enabled: nothing moves
        reg_write(ADDR_RX_HI, 8'h00);
        reg_write(ADDR_RX_LO, 8'h28);
        reg_write(ADDR_TX_HI, 8'h00);
        reg_write(ADDR_TX_LO, 8'h28);
        mode = pht_mode_s'({1'b1, 1'b0, PHT_FMT_LIN8});
        txValid = 1'b1;
        wait_frames(3);
        check("frameSeen", 17'h1, 17'(frameSeen));
        check("rxValid", 17'h0, 17'(rxValid));
        // every format, three slot places, both release edges, last with nothing held
        for (int i = 0; i < 6; i++)
            tx_case(pht_fmt_e'(i % 4), 16'(8 + 8 * (i % 3)), i[0], 16'($urandom), i != 5);
        wait_frames(1);
        capEn = 1'b0;
        // disabled port with a reachable start must stay silent
        mode.enable = 1'b0;
        txAt = 16'h0028;
        reg_write(ADDR_TX_LO, 8'h08);
        wait_frames(2);
        // receive slot set while idle, then the fifo fills with the consumer stalled
        reg_write(ADDR_TX_LO, 8'h28);
        reg_write(ADDR_RX_LO, 8'h08);
        rxAt = 16'h0008;
        rxWord = 16'($urandom);
        wait_frames(1);
        mode.enable = 1'b1;
        wait_frames(36);
        mode.enable = 1'b0;
        check("rxOverrun", 17'h1, 17'(rxOverrun));
        repeat (33) rxQ.push_back({8'h00, rxWord[7:0]});
        overrunClear = 1'b1;
        @(negedge mclk);
        overrunClear = 1'b0;
        @(negedge mclk);
        check("rxOverrun", 17'h0, 17'(rxOverrun));
        rxReady = 1'b1;
        for (int n = 0; n < 200 && rxValid !== 1'b0; n++)
            @(negedge mclk);
        check("rxValid", 17'h0, 17'(rxValid));
        // one linear sample spans two receive slots back to back
        rxQ.push_back(rxWord);
        rxBits = 5'h10;
        mode = pht_mode_s'({1'b0, 1'b0, PHT_FMT_LIN16});
        wait_frames(1);
        mode.enable = 1'b1;
        wait_frames(1);
        mode.enable = 1'b0;
        wait_frames(1);
        check("rx notes left", 17'h0, 17'(rxQ.size()));
        check("tx notes left", 17'h0, 17'(txQ.size()));
        check("strayCount", 17'h0, {1'b0, strayCount});
        give_verdict();
    end
endmodule
